//--- logic/mtcs_pkg.sv
// Package for the MAC transmit/receive control and status block.
// Holds register indices, field positions, reset values, length limits and the
// packed structs that carry datapath events into the block.
package mtcs_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [5:0] IDX_NET_CONTROL = 6'h00;
	localparam logic [5:0] IDX_TX_DONE     = 6'h01;
	localparam logic [5:0] IDX_TX_CONTROL  = 6'h02;
	localparam logic [5:0] IDX_TX_STATUS1  = 6'h03;
	localparam logic [5:0] IDX_TX_STATUS2  = 6'h04;
	localparam logic [5:0] IDX_RX_CONTROL  = 6'h05;
	localparam logic [5:0] IDX_RX_STATUS   = 6'h06;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Transmit control fields.
	localparam int TC_REQUEST     = 0;
	localparam int TC_SKIP_FCS1   = 1;
	localparam int TC_SKIP_PAD1   = 2;
	localparam int TC_SKIP_FCS2   = 3;
	localparam int TC_SKIP_PAD2   = 4;
	localparam int TC_RETRY_FOREV = 5;
	localparam int TC_TX_GUARD    = 6;

	// Transmit status fields, the same for both indices.
	localparam int TS_LEN_TIMEOUT = 7;
	localparam int TS_CARR_LOST   = 6;
	localparam int TS_NO_CARRIER  = 5;
	localparam int TS_LATE_HIT    = 4;
	localparam int TS_COLLISION   = 3;
	localparam int TS_RETRY_ABORT = 2;

	// Receive control fields.
	localparam int RC_ENABLE      = 0;
	localparam int RC_ANY_DEST    = 1;
	localparam int RC_PASS_RUNT   = 2;
	localparam int RC_ALL_GROUP   = 3;
	localparam int RC_DROP_FCS    = 4;
	localparam int RC_DROP_LONG   = 5;
	localparam int RC_RX_GUARD    = 6;

	// Network control and completion fields.
	localparam int NC_LOOP_LSB    = 1;
	localparam int ND_INDEX1      = 2;
	localparam int ND_INDEX2      = 3;

	// Loopback encodings.
	localparam logic [1:0] LOOP_NORMAL   = 2'b00;
	localparam logic [1:0] LOOP_MAC_INT  = 2'b01;
	localparam logic [1:0] LOOP_PHY_100M = 2'b10;

	// Length limits in bytes and the collision policy.
	localparam logic [11:0] TX_LENGTH_LIMIT = 12'd2048;
	localparam logic [11:0] RX_LENGTH_LIMIT = 12'd2048;
	localparam logic [11:0] OVERSIZE_LIMIT  = 12'd1522;
	localparam logic [11:0] SLOT_BYTES      = 12'd64;
	localparam logic [4:0]  RETRY_LIMIT     = 5'd16;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Events from the transmit datapath.
	typedef struct packed {
		logic byte_sent;
		logic collision;
		logic carrier;
		logic frame_done;
	} mtcs_tx_ev_t;

	// Events from the receive datapath.
	typedef struct packed {
		logic frame_start;
		logic byte_rcvd;
		logic dest_group;
		logic dest_match;
		logic late_hit;
		logic symbol_err;
		logic odd_bits;
		logic fcs_bad;
		logic overflow;
		logic frame_end;
	} mtcs_rx_ev_t;

endpackage : mtcs_pkg

//--- logic/mtcs_core.sv
// MAC transmit/receive control and status registers with their sequencing.
// Assumes an AXI4-Lite master and a MAC datapath that reports byte and frame
// events synchronous to aclk.
`timescale 1ns/1ps
module mtcs_core
	import mtcs_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [7:0]            s_axi_araddr,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	input  wire mtcs_pkg::mtcs_tx_ev_t tx_ev,
	output logic                       tx_start,
	output logic                       tx_index2,
	output logic                       tx_pad_on,
	output logic                       tx_fcs_on,
	output logic                       tx_abort,
	output logic                       tx_retry,
	output logic [1:0]                 loopback_select,
	input  wire mtcs_pkg::mtcs_rx_ev_t rx_ev,
	output logic                       rx_cut,
	output logic                       rx_accept,
	output logic                       rx_reject
);
	typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_END} mtcs_tx_state_t;

	logic [7:0]     tx_ctrl_reg, rx_ctrl_reg, rx_stat_reg, done_reg;
	logic [7:0]     tx_stat_reg [2];
	logic [1:0]     loop_reg;
	mtcs_tx_state_t tx_state_reg;
	logic           cur_idx_reg;
	logic [11:0]    tx_cnt_reg, rx_cnt_reg;
	logic [4:0]     col_cnt_reg;
	logic [7:0]     tx_flags_reg;
	logic           carrier_seen_reg, rx_busy_reg;
	logic [7:0]     rx_flags_reg;
	logic           rx_oversize_reg;
	logic           aw_have_reg, w_have_reg;
	logic [5:0]     aw_idx_reg;
	logic [7:0]     w_byte_reg;
	logic           w_lane_reg;

	// Bus decode: a write fires once address and data are both held.
	wire       wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire       rd_fire   = s_axi_arvalid && s_axi_arready;
	wire [5:0] rd_idx    = s_axi_araddr[7:2];
	wire       wr_mapped = aw_idx_reg <= IDX_RX_STATUS;
	wire       rd_mapped = rd_idx <= IDX_RX_STATUS;
	wire       wr_en     = wr_fire && w_lane_reg;
	wire       wr_net    = wr_en && aw_idx_reg == IDX_NET_CONTROL;
	wire       wr_done   = wr_en && aw_idx_reg == IDX_TX_DONE;
	wire       wr_txc    = wr_en && aw_idx_reg == IDX_TX_CONTROL;
	wire       wr_rxc    = wr_en && aw_idx_reg == IDX_RX_CONTROL;
	wire       rd_done   = rd_fire && rd_idx == IDX_TX_DONE;

	// Read data selection; reserved bits read as zero.
	logic [7:0] rd_byte;
	always_comb
	begin
		case (rd_idx)
			IDX_NET_CONTROL: rd_byte = {5'h00, loop_reg, 1'b0};
			IDX_TX_DONE:     rd_byte = done_reg;
			IDX_TX_CONTROL:  rd_byte = tx_ctrl_reg;
			IDX_TX_STATUS1:  rd_byte = tx_stat_reg[0];
			IDX_TX_STATUS2:  rd_byte = tx_stat_reg[1];
			IDX_RX_CONTROL:  rd_byte = rx_ctrl_reg;
			IDX_RX_STATUS:   rd_byte = rx_stat_reg;
			default:         rd_byte = 8'h00;
		endcase
	end

	// Transmit decode: mode bits, loopback masking and the two ends of a packet.
	wire tx_guard_on   = !tx_ctrl_reg[TC_TX_GUARD];
	wire mac_loop      = loop_reg == LOOP_MAC_INT;
	wire tx_sending    = tx_state_reg == TX_SEND;
	wire tx_over_len   = tx_sending && tx_ev.byte_sent && tx_guard_on
		&& tx_cnt_reg >= TX_LENGTH_LIMIT;
	wire col_hit       = tx_sending && tx_ev.collision;
	wire col_last      = col_hit && col_cnt_reg == RETRY_LIMIT - 5'd1;
	wire col_abort     = col_last && !tx_ctrl_reg[TC_RETRY_FOREV];
	wire late_hit      = col_hit && tx_cnt_reg >= SLOT_BYTES;
	wire carrier_drop  = tx_sending && !tx_ev.carrier && carrier_seen_reg && !mac_loop;
	wire tx_finish     = tx_sending && (tx_ev.frame_done || tx_over_len || col_abort);
	wire no_carrier    = !carrier_seen_reg && !tx_ev.carrier && !mac_loop;

	// Final outcome flags of the packet, merged with the events of this cycle.
	logic [7:0] tx_outcome;
	always_comb
	begin
		tx_outcome                 = tx_flags_reg;
		tx_outcome[TS_LEN_TIMEOUT] = tx_flags_reg[TS_LEN_TIMEOUT] | tx_over_len;
		tx_outcome[TS_CARR_LOST]   = tx_flags_reg[TS_CARR_LOST] | carrier_drop;
		tx_outcome[TS_NO_CARRIER]  = no_carrier;
		tx_outcome[TS_LATE_HIT]    = tx_flags_reg[TS_LATE_HIT] | late_hit;
		tx_outcome[TS_COLLISION]   = tx_flags_reg[TS_COLLISION] | col_hit;
		tx_outcome[TS_RETRY_ABORT] = col_abort;
	end

	// Bus write side: address and data are taken in either order.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_idx_reg    <= 6'h00;
			w_byte_reg   <= 8'h00;
			w_lane_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_idx_reg    <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
				w_byte_reg   <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_have_reg   <= 1'b0;
				w_have_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Bus read side: one read at a time, answered the cycle after it is taken.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_byte};
			s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else
			s_axi_arready <= !s_axi_rvalid;
	end

	// Control registers; the request bit is cleared by hardware at packet end.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_ctrl_reg <= RST_BYTE;
			rx_ctrl_reg <= RST_BYTE;
			loop_reg    <= LOOP_NORMAL;
		end
		else
		begin
			if (wr_txc)
				// A packet end in the same cycle still clears an old request.
				tx_ctrl_reg <= {1'b0, w_byte_reg[6:1],
					w_byte_reg[0] | (tx_ctrl_reg[0] && !tx_finish)};
			else if (tx_finish)
				tx_ctrl_reg[TC_REQUEST] <= 1'b0;
			if (wr_rxc)
				rx_ctrl_reg <= {1'b0, w_byte_reg[6:0]};
			if (wr_net)
				loop_reg <= w_byte_reg[NC_LOOP_LSB +: 2];
		end
	end

	// Completion flags: set wins over a read or a write-one clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			done_reg <= RST_BYTE;
		else
		begin
			done_reg[ND_INDEX1] <= (tx_finish && !cur_idx_reg)
				|| (done_reg[ND_INDEX1] && !rd_done
				&& !(wr_done && w_byte_reg[ND_INDEX1]));
			done_reg[ND_INDEX2] <= (tx_finish && cur_idx_reg)
				|| (done_reg[ND_INDEX2] && !rd_done
				&& !(wr_done && w_byte_reg[ND_INDEX2]));
		end
	end

	// Transmit sequencer: start, count bytes and collisions, then finish.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state_reg     <= TX_IDLE;
			cur_idx_reg      <= 1'b0;
			tx_cnt_reg       <= 12'h000;
			col_cnt_reg      <= 5'h00;
			tx_flags_reg     <= 8'h00;
			carrier_seen_reg <= 1'b0;
			tx_start         <= 1'b0;
			tx_abort         <= 1'b0;
			tx_retry         <= 1'b0;
			tx_stat_reg[0]   <= RST_BYTE;
			tx_stat_reg[1]   <= RST_BYTE;
		end
		else
		begin
			tx_start <= 1'b0;
			tx_abort <= 1'b0;
			tx_retry <= 1'b0;
			case (tx_state_reg)
				TX_IDLE:
				begin
					if (tx_ctrl_reg[TC_REQUEST])
					begin
						tx_state_reg     <= TX_SEND;
						tx_start         <= 1'b1;
						tx_cnt_reg       <= 12'h000;
						col_cnt_reg      <= 5'h00;
						tx_flags_reg     <= 8'h00;
						carrier_seen_reg <= 1'b0;
					end
				end
				TX_SEND:
				begin
					tx_flags_reg <= tx_outcome;
					if (tx_ev.carrier)
						carrier_seen_reg <= 1'b1;
					if (tx_ev.byte_sent && tx_cnt_reg <= TX_LENGTH_LIMIT)
						tx_cnt_reg <= tx_cnt_reg + 12'd1;
					if (col_hit && !col_abort)
					begin
						tx_retry    <= 1'b1;
						tx_cnt_reg  <= 12'h000;
						col_cnt_reg <= col_last ? 5'h00 : col_cnt_reg + 5'd1;
					end
					if (tx_finish)
					begin
						tx_state_reg             <= TX_END;
						tx_abort                 <= tx_over_len || col_abort;
						tx_stat_reg[cur_idx_reg] <= {tx_outcome[7:2], 2'b00};
					end
				end
				TX_END:
				begin
					tx_state_reg <= TX_IDLE;
					cur_idx_reg  <= !cur_idx_reg;
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// Per-index padding and FCS steering for the packet now being sent.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_index2       <= 1'b0;
			tx_pad_on       <= 1'b1;
			tx_fcs_on       <= 1'b1;
			loopback_select <= LOOP_NORMAL;
		end
		else
		begin
			tx_index2       <= cur_idx_reg;
			tx_pad_on       <= cur_idx_reg ? !tx_ctrl_reg[TC_SKIP_PAD2]
				: !tx_ctrl_reg[TC_SKIP_PAD1];
			tx_fcs_on       <= cur_idx_reg ? !tx_ctrl_reg[TC_SKIP_FCS2]
				: !tx_ctrl_reg[TC_SKIP_FCS1];
			loopback_select <= loop_reg;
		end
	end

	// Receive decode: guard, error flags and the acceptance filter.
	wire rx_guard_on  = !rx_ctrl_reg[RC_RX_GUARD];
	wire rx_over_len  = rx_busy_reg && rx_ev.byte_rcvd && rx_guard_on
		&& rx_cnt_reg >= RX_LENGTH_LIMIT;
	wire rx_runt      = rx_cnt_reg < SLOT_BYTES;
	wire dest_ok      = rx_ctrl_reg[RC_ANY_DEST] || rx_ev.dest_match
		|| (rx_ev.dest_group && rx_ctrl_reg[RC_ALL_GROUP]);
	wire rx_closing   = rx_busy_reg && (rx_ev.frame_end || rx_over_len);

	// Error flags of the frame, merged with the events of this cycle.
	logic [7:0] rx_outcome;
	always_comb
	begin
		rx_outcome    = rx_flags_reg;
		rx_outcome[7] = rx_runt;
		rx_outcome[6] = rx_flags_reg[6] | rx_ev.dest_group;
		rx_outcome[5] = rx_flags_reg[5] | rx_ev.late_hit;
		rx_outcome[4] = rx_flags_reg[4] | rx_over_len;
		rx_outcome[3] = rx_flags_reg[3] | rx_ev.symbol_err;
		rx_outcome[2] = rx_ev.frame_end && rx_ev.odd_bits;
		rx_outcome[1] = rx_ev.frame_end && rx_ev.fcs_bad;
		rx_outcome[0] = rx_flags_reg[0] | rx_ev.overflow;
	end

	wire rx_keep = dest_ok && !rx_outcome[4] && !rx_outcome[0]
		&& !(rx_ctrl_reg[RC_DROP_FCS] && rx_outcome[1])
		&& !(rx_ctrl_reg[RC_DROP_LONG] && rx_oversize_reg)
		&& !(rx_runt && !rx_ctrl_reg[RC_PASS_RUNT]);

	// Receive tracker: frames only start while reception is enabled.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_busy_reg     <= 1'b0;
			rx_cnt_reg      <= 12'h000;
			rx_flags_reg    <= 8'h00;
			rx_oversize_reg <= 1'b0;
			rx_stat_reg     <= RST_BYTE;
			rx_cut          <= 1'b0;
			rx_accept       <= 1'b0;
			rx_reject       <= 1'b0;
		end
		else
		begin
			rx_cut    <= rx_over_len;
			rx_accept <= rx_closing && rx_keep;
			rx_reject <= rx_closing && !rx_keep;
			if (!rx_busy_reg)
			begin
				if (rx_ev.frame_start && rx_ctrl_reg[RC_ENABLE])
				begin
					rx_busy_reg     <= 1'b1;
					rx_cnt_reg      <= 12'h000;
					rx_flags_reg    <= 8'h00;
					rx_oversize_reg <= 1'b0;
				end
			end
			else
			begin
				rx_flags_reg <= rx_outcome;
				if (rx_ev.byte_rcvd && rx_cnt_reg <= RX_LENGTH_LIMIT)
					rx_cnt_reg <= rx_cnt_reg + 12'd1;
				if (rx_ev.byte_rcvd && rx_cnt_reg >= OVERSIZE_LIMIT)
					rx_oversize_reg <= 1'b1;
				if (rx_closing)
				begin
					rx_busy_reg <= 1'b0;
					rx_stat_reg <= rx_outcome;
				end
			end
		end
	end

endmodule : mtcs_core

//--- verification/mtcs_core_assertions.sv
// Concurrent checks on the ports of mtcs_core, bound to every instance.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module mtcs_core_assertions
	import mtcs_pkg::*;
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic [7:0]            s_axi_awaddr,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic                  s_axi_bvalid,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic [31:0]           s_axi_rdata,
	input wire mtcs_pkg::mtcs_tx_ev_t tx_ev,
	input wire logic                  tx_start,
	input wire logic                  tx_retry,
	input wire logic                  tx_abort,
	input wire logic                  rx_cut,
	input wire logic                  rx_accept,
	input wire logic                  rx_reject
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Bus requests that the slave takes.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// Write answers carry the response that the address deserves; read answers come the next cycle.
	write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid &&
		s_axi_bresp == (($past(s_axi_awaddr, 2) > 8'h1B) ? RESP_SLVERR : RESP_OKAY))
		else $error("write answer late or wrong");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer missing");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	// Transmit sequencing.
	start_gap_a: assert property (tx_start |=> !tx_start [*2])
		else $error("packet started too soon");
	abort_alone_a: assert property (tx_abort |-> !tx_retry && !tx_start)
		else $error("abort with retry or start");
	retry_cause_a: assert property (tx_retry |-> $past(tx_ev.collision))
		else $error("retry without collision");
	// Receive frame close.
	rx_close_a: assert property (rx_accept |-> !rx_reject)
		else $error("frame both accepted and rejected");
	cut_reject_a: assert property (rx_cut |-> ##[0:2] rx_reject)
		else $error("cut frame not rejected");
endmodule : mtcs_core_assertions

bind mtcs_core mtcs_core_assertions i_mtcs_core_assertions (.*);

//--- verification/mtcs_dp_model.sv
// Behavioural MAC datapath and PHY beside mtcs_core.
// Assumes the bench calls cfg_tx before each request and rx_frame per frame.
`timescale 1ns/1ps
module mtcs_dp_model
	import mtcs_pkg::*;
(
	input  wire logic             aclk,
	input  wire logic             tx_start,
	input  wire logic             tx_abort,
	output mtcs_pkg::mtcs_tx_ev_t tx_ev,
	output mtcs_pkg::mtcs_rx_ev_t rx_ev
);
	int t_len, t_nc, t_ca, t_car;

	// Shape of the next frame: length, collisions, their byte, carrier mode.
	task cfg_tx(input int len, nc, ca, car);
		t_len = len;
		t_nc = nc;
		t_ca = ca;
		t_car = car;
	endtask : cfg_tx

	// Sends bytes, restarts after each collision and stops when aborted.
	task send_frame();
		int b, c;
		logic ab, col;
		b = 0;
		c = 0;
		ab = 1'b0;
		tx_ev.carrier <= (t_car != 1);
		while (b < t_len && !ab)
		begin
			@(posedge aclk);
			ab = tx_abort;
			col = (c < t_nc) && (b == t_ca);
			tx_ev.collision <= col && !ab;
			tx_ev.byte_sent <= !col && !ab;
			c = c + col;
			b = col ? 0 : b + 1;
			if (t_car == 2 && b == t_len / 2) tx_ev.carrier <= 1'b0;
		end
		@(posedge aclk);
		ab = ab || tx_abort;
		tx_ev.byte_sent <= 1'b0;
		tx_ev.collision <= 1'b0;
		@(posedge aclk);
		ab = ab || tx_abort;
		tx_ev.frame_done <= !ab;
		@(posedge aclk);
		tx_ev <= '0;
	endtask : send_frame

	// One frame with mid-frame events at half length and end flags at the close.
	task rx_frame(input int len, input logic [6:0] fl);
		int i;
		@(posedge aclk);
		rx_ev.frame_start <= 1'b1;
		rx_ev.dest_group <= fl[6];
		rx_ev.dest_match <= fl[5];
		for (i = 0; i < len; i++)
		begin
			@(posedge aclk);
			rx_ev.frame_start <= 1'b0;
			rx_ev.byte_rcvd <= 1'b1;
			rx_ev.late_hit <= fl[4] && i == len / 2;
			rx_ev.symbol_err <= fl[3] && i == len / 2;
			rx_ev.overflow <= fl[0] && i == len / 2;
		end
		@(posedge aclk);
		rx_ev.byte_rcvd <= 1'b0;
		rx_ev.odd_bits <= fl[2];
		rx_ev.fcs_bad <= fl[1];
		rx_ev.frame_end <= 1'b1;
		@(posedge aclk);
		rx_ev <= '0;
	endtask : rx_frame

	// A frame goes out for every packet start.
	initial
	begin
		tx_ev = '0;
		rx_ev = '0;
		forever
		begin
			@(posedge aclk);
			if (tx_start) send_frame();
		end
	end
endmodule : mtcs_dp_model

//--- verification/mtcs_core_tb_top.sv
// Self-checking bench for mtcs_core with the datapath model.
// Acts as AXI4-Lite master; all stimulus changes on rising aclk.
`timescale 1ns/1ps
module mtcs_core_tb_top;
	import mtcs_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, loopback_select;
	logic tx_start, tx_index2, tx_pad_on, tx_fcs_on, tx_abort, tx_retry;
	logic rx_cut, rx_accept, rx_reject, st_d, cap_pad, cap_fcs, cap_idx2;
	logic idx2 = 1'b0;
	mtcs_tx_ev_t tx_ev;
	mtcs_rx_ev_t rx_ev;
	int n_errors = 0, n_checks = 0, n_acc = 0, n_rej = 0, n_cut = 0;
	logic [31:0] seed = 32'h7D882CA6;
	logic [7:0] ts_last [2] = '{8'h00, 8'h00};
	logic [7:0] rs_last = 8'h00;

	mtcs_core i_mtcs_core (.*);
	mtcs_dp_model i_mtcs_dp_model (.*);

	always #5 aclk = ~aclk;

	// Samples transmit levels one cycle into a packet and counts frame closes.
	always @(posedge aclk)
	begin
		st_d <= tx_start;
		if (st_d)
		begin
			cap_pad <= tx_pad_on;
			cap_fcs <= tx_fcs_on;
			cap_idx2 <= tx_index2;
		end
		n_acc <= n_acc + rx_accept;
		n_rej <= n_rej + rx_reject;
		n_cut <= n_cut + rx_cut;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task print_verdict();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write with address and data offered together; held until each is taken.
	task axw(input logic [5:0] i, input logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw

	task axr(input logic [5:0] i, output logic [7:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr

	task rdc(input string nm, input logic [5:0] i, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		axr(i, d, r);
		chk(nm, e, d);
	endtask : rdc

	// Status expected after a packet of the given shape.
	function automatic logic [7:0] exp_ts(logic [7:0] c, int len, nc, ca, car, logic [1:0] lb);
		logic [7:0] t;
		t = 8'h00;
		t[TS_COLLISION] = nc > 0;
		t[TS_LATE_HIT] = nc > 0 && ca >= SLOT_BYTES;
		t[TS_RETRY_ABORT] = nc >= RETRY_LIMIT && !c[TC_RETRY_FOREV];
		t[TS_LEN_TIMEOUT] = !t[TS_RETRY_ABORT] && len > TX_LENGTH_LIMIT && !c[TC_TX_GUARD];
		t[TS_NO_CARRIER] = lb != LOOP_MAC_INT && car == 1;
		t[TS_CARR_LOST] = lb != LOOP_MAC_INT && car == 2;
		return t;
	endfunction : exp_ts

	// Verdict bit above the receive status expected for a frame.
	function automatic logic [8:0] exp_rx(logic [7:0] c, int len, logic [6:0] f);
		logic [7:0] s;
		logic to;
		to = len > RX_LENGTH_LIMIT && !c[RC_RX_GUARD];
		s = {len < SLOT_BYTES, f[6], f[4], to, f[3], f[2] && !to, f[1] && !to, f[0]};
		return {(c[RC_ANY_DEST] || f[5] || (f[6] && c[RC_ALL_GROUP])) && !to && !f[0]
			&& !(s[1] && c[RC_DROP_FCS]) && !(len > OVERSIZE_LIMIT && c[RC_DROP_LONG])
			&& !(s[7] && !c[RC_PASS_RUNT]), s};
	endfunction : exp_rx

	// One packet: request, poll completion, then check levels and both status slots.
	task do_tx(input logic [7:0] c, input int len, nc, ca, car, input logic [1:0] lb);
		logic [7:0] d;
		logic [1:0] r;
		int n;
		axw(IDX_NET_CONTROL, {5'h00, lb, 1'b0}, r);
		@(posedge aclk);
		chk("loopback", lb, loopback_select);
		i_mtcs_dp_model.cfg_tx(len, nc, ca, car);
		axw(IDX_TX_CONTROL, c | 8'h01, r);
		d = 8'h00;
		for (n = 0; n < 3000 && d == 8'h00; n++)
			axr(IDX_TX_DONE, d, r);
		chk("done", idx2 ? 8'h08 : 8'h04, d);
		rdc("done clear", IDX_TX_DONE, 8'h00);
		chk("pad", !(idx2 ? c[TC_SKIP_PAD2] : c[TC_SKIP_PAD1]), cap_pad);
		chk("fcs", !(idx2 ? c[TC_SKIP_FCS2] : c[TC_SKIP_FCS1]), cap_fcs);
		chk("index", idx2, cap_idx2);
		ts_last[idx2] = exp_ts(c, len, nc, ca, car, lb);
		rdc("status1", IDX_TX_STATUS1, ts_last[0]);
		rdc("status2", IDX_TX_STATUS2, ts_last[1]);
		rdc("request", IDX_TX_CONTROL, c & 8'h7E);
		idx2 = !idx2;
	endtask : do_tx

	// One received frame: close verdict, guard cut and status.
	task do_rx(input logic [7:0] c, input int len, input logic [6:0] f);
		logic [8:0] e;
		logic [1:0] r;
		int a, j, k;
		e = exp_rx(c, len, f);
		axw(IDX_RX_CONTROL, c, r);
		rdc("rx control", IDX_RX_CONTROL, c & 8'h7F);
		a = n_acc;
		j = n_rej;
		k = n_cut;
		i_mtcs_dp_model.rx_frame(len, f);
		repeat (4) @(posedge aclk);
		if (c[RC_ENABLE]) rs_last = e[7:0];
		chk("accept", c[RC_ENABLE] && e[8], n_acc - a);
		chk("reject", c[RC_ENABLE] && !e[8], n_rej - j);
		chk("cut", c[RC_ENABLE] && e[4], n_cut - k);
		rdc("rx status", IDX_RX_STATUS, rs_last);
	endtask : do_rx

	// Main sequence.
	initial
	begin
		logic [1:0] r;
		logic [31:0] v;
		logic [7:0] d;
		int i;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("pad reset", 1'b1, tx_pad_on);
		for (i = 0; i < 7; i++)
			rdc("reset", 6'(i), RST_BYTE);
		axw(6'h07, 8'hFF, r);
		chk("unmapped", RESP_SLVERR, r);
		axr(6'h07, d, r);
		chk("rd unmapped", RESP_SLVERR, r);
		axw(IDX_TX_STATUS1, 8'hFF, r);
		rdc("read only", IDX_TX_STATUS1, 8'h00);
		do_tx(8'h00, 100, 0, 0, 0, LOOP_NORMAL);
		do_tx(8'h18, 80, 1, 63, 0, LOOP_NORMAL);
		do_tx(8'h06, 80, 1, 64, 0, LOOP_NORMAL);
		do_tx(8'h00, 40, 15, 5, 0, LOOP_NORMAL);
		do_tx(8'h00, 40, 16, 5, 0, LOOP_NORMAL);
		do_tx(8'h20, 40, 17, 5, 0, LOOP_NORMAL);
		do_tx(8'h00, 2049, 0, 0, 0, LOOP_NORMAL);
		do_tx(8'h40, 2100, 0, 0, 0, LOOP_NORMAL);
		do_tx(8'h0A, 100, 0, 0, 1, LOOP_NORMAL);
		do_tx(8'h14, 100, 0, 0, 2, LOOP_PHY_100M);
		do_tx(8'h00, 100, 0, 0, 1, LOOP_MAC_INT);
		axw(IDX_NET_CONTROL, 8'h06, r);
		@(posedge aclk);
		chk("loop reserved", 2'b11, loopback_select);
		// Completion flag left unread, then cleared by writing one to it.
		i_mtcs_dp_model.cfg_tx(70, 0, 0, 0);
		axw(IDX_TX_CONTROL, 8'h01, r);
		repeat (200) @(posedge aclk);
		axw(IDX_TX_DONE, idx2 ? 8'h08 : 8'h04, r);
		rdc("done w1c", IDX_TX_DONE, 8'h00);
		idx2 = !idx2;
		do_rx(8'h00, 100, 7'h20);
		do_rx(8'h01, 100, 7'h40);
		do_rx(8'h09, 100, 7'h40);
		do_rx(8'h03, 63, 7'h00);
		do_rx(8'h05, 63, 7'h20);
		do_rx(8'h21, 1523, 7'h20);
		do_rx(8'h21, 1522, 7'h2C);
		do_rx(8'h11, 100, 7'h22);
		do_rx(8'h01, 2049, 7'h3D);
		do_rx(8'h41, 2100, 7'h20);
		for (i = 0; i < 10; i++)
		begin
			v = xs();
			do_rx({1'b0, v[6:1], v[9:8] != 2'b00}, 20 + int'(v[19:10]), v[26:20]);
		end
		print_verdict();
	end

	// Cuts a hang short.
	initial
	begin
		#1000000;
		n_errors++;
		print_verdict();
	end
endmodule : mtcs_core_tb_top
